// *** hw/lqog_top.sv ***
// linear quality output gate: config registers, grade compare, quality pin
// assumes an AXI4-Lite master and a grader that pulses grade_valid per symbol
`timescale 1ns/1ns

module lqog_top
   import lqog_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NPAR*GRADE_W-1:0] grade_in,
   input wire logic grade_valid,
   output logic quality_out,
   output logic irq
);
   logic aw_have_q;
   logic w_have_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic rd_take;
   logic [31:0] wr_val;
   logic [NPAR-1:0] en_q;
   logic [NPAR*GRADE_W-1:0] thr_q;
   logic [NPAR*GRADE_W-1:0] grade_q;
   logic [NPAR-1:0] fail_w;
   logic [NPAR-1:0] fail_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [31:0] cmd_last_q;

   // byte-lane merge of a write into the current register image
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
      return {a[ADDR_W-1:2], 2'h0};
   endfunction

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = word_addr(a);
      return (w == ADDR_ENABLE) || (w == ADDR_THRESH) || (w == ADDR_CMD) || (w == ADDR_GRADE) ||
             (w == ADDR_FAILS) || (w == ADDR_IRQ_STAT) || (w == ADDR_IRQ_MASK);
   endfunction

   // command word image built from the live enables and thresholds
   function automatic logic [31:0] pack_cmd(input logic [NPAR-1:0] e,
                                            input logic [NPAR*GRADE_W-1:0] t);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < NPAR; i++) begin
         r[i*CMD_FIELD_W + CMD_EN_POS] = e[i];
         r[i*CMD_FIELD_W + CMD_THR_POS +: GRADE_W] = t[i*GRADE_W +: GRADE_W];
      end
      return r;
   endfunction

   function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
      logic [31:0] r;
      r = 32'h0;
      case (word_addr(a))
         ADDR_ENABLE: r[NPAR-1:0] = en_q;
         ADDR_THRESH: r[NPAR*GRADE_W-1:0] = thr_q;
         ADDR_CMD: r = pack_cmd(en_q, thr_q);
         ADDR_GRADE: r[NPAR*GRADE_W-1:0] = grade_q;
         ADDR_FAILS: r[NPAR-1:0] = fail_q;
         ADDR_IRQ_STAT: r[IRQ_W-1:0] = irq_stat_q;
         ADDR_IRQ_MASK: r[IRQ_W-1:0] = irq_mask_q;
         default: r = 32'h0;
      endcase
      return r;
   endfunction

   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   // a process, not an assign, so that register changes read inside reg_read are seen too
   always_comb begin
      wr_val = merge_strb(reg_read(aw_addr_q), w_data_q, w_strb_q);
   end

   // write address channel: one address held until its response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // write data channel, independent of the address so either may lead
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= reg_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: data sampled at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= reg_read(s_axi_araddr);
         s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // enables and thresholds: direct registers or the packed command word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= EN_RESET;
         thr_q <= THR_RESET;
      end else if (do_write) begin
         case (word_addr(aw_addr_q))
            ADDR_ENABLE: en_q <= wr_val[NPAR-1:0];
            ADDR_THRESH: thr_q <= wr_val[NPAR*GRADE_W-1:0];
            ADDR_CMD: begin
               for (int i = 0; i < NPAR; i++) begin
                  en_q[i] <= wr_val[i*CMD_FIELD_W + CMD_EN_POS];
                  thr_q[i*GRADE_W +: GRADE_W] <= wr_val[i*CMD_FIELD_W + CMD_THR_POS +: GRADE_W];
               end
            end
            default: begin
               en_q <= en_q;
            end
         endcase
      end
   end

   // helper copy of the last command word, read only by the checks below
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_last_q <= 32'h0;
      end else if (do_write && word_addr(aw_addr_q) == ADDR_CMD) begin
         cmd_last_q <= wr_val;
      end
   end

   // grades start at the best code so nothing fails before the first symbol
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         grade_q <= GRADE_RESET;
      end else if (grade_valid) begin
         grade_q <= grade_in;
      end
   end

   lqog_cmp u_cmp (
      .en(en_q),
      .thr(thr_q),
      .grade(grade_q),
      .fail(fail_w)
   );

   // output follows config changes too, not only new grades
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         quality_out <= 1'b0;
         fail_q <= '0;
      end else begin
         quality_out <= |fail_w;
         fail_q <= fail_w;
      end
   end

   always_comb begin
      irq_set = '0;
      irq_set[IRQ_FAIL_BIT] = (|fail_w) && !quality_out;
      irq_set[IRQ_GRADE_BIT] = grade_valid;
      irq_clr = (rd_take && word_addr(s_axi_araddr) == ADDR_IRQ_STAT) ? irq_stat_q : '0;
      // a new event in the clearing cycle survives
      irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= '0;
         irq_mask_q <= IRQ_MASK_RESET;
         irq <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         if (do_write && word_addr(aw_addr_q) == ADDR_IRQ_MASK) begin
            irq_mask_q <= wr_val[IRQ_W-1:0];
         end
         // a mask write reaches irq one edge after the mask register takes it
         irq <= |(irq_stat_d & irq_mask_q);
      end
   end

   // reference compare per slot, independent of the comparator instance;
   // all values come in as arguments so the checks only ever see sampled values
   function automatic logic below_ref(input logic e, input logic [GRADE_W-1:0] t,
                                      input logic [GRADE_W-1:0] g);
      return e && (g < t);
   endfunction

   logic [NPAR-1:0] ref_below;

   always_comb begin
      for (int i = 0; i < NPAR; i++) begin
         ref_below[i] = below_ref(en_q[i], thr_q[i*GRADE_W +: GRADE_W], grade_q[i*GRADE_W +: GRADE_W]);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_cmd_write;
      do_write && (word_addr(aw_addr_q) == ADDR_CMD);
   endsequence

   sequence s_none_failing;
      !(|fail_w);
   endsequence

   sequence s_resp_waiting;
      s_axi_bvalid && !s_axi_bready;
   endsequence

   sequence s_read_waiting;
      s_axi_rvalid && !s_axi_rready;
   endsequence

   a_overall_grade_drive: assert property (ref_below[PAR_OVERALL] |=> quality_out && fail_q[PAR_OVERALL])
      else $error("overall grade below threshold did not drive output");
   a_edge_grade_drive: assert property (ref_below[PAR_EDGE] |=> quality_out && fail_q[PAR_EDGE])
      else $error("edge determination below threshold did not drive output");
   a_decode_grade_drive: assert property (ref_below[PAR_DECODE] |=> quality_out)
      else $error("decode below threshold did not drive output");
   a_contrast_group_drive: assert property (
      ref_below[PAR_CONTRAST] || ref_below[PAR_MIN_REFL] || ref_below[PAR_MIN_EDGE] |=> quality_out)
      else $error("contrast group below threshold did not drive output");
   a_late_group_drive: assert property (
      ref_below[PAR_MODULATION] || ref_below[PAR_DEFECTS] || ref_below[PAR_DECODABILITY] ||
      ref_below[PAR_QUIET_ZONE] |=> quality_out)
      else $error("late group below threshold did not drive output");
   a_enable_reset_off: assert property ($rose(aresetn) |-> en_q == EN_RESET && !quality_out)
      else $error("enables not disabled after reset");
   a_grade_d_floor: assert property (thr_q[GRADE_W-1:0] == GRADE_D |-> !fail_w[PAR_OVERALL])
      else $error("grade D threshold reported a failure");
   a_thresh_reset_b: assert property ($rose(aresetn) |-> thr_q == THR_RESET)
      else $error("thresholds not grade B after reset");
   a_cmd_field_order: assert property (s_cmd_write |=>
      en_q[PAR_QUIET_ZONE] == cmd_last_q[PAR_QUIET_ZONE*CMD_FIELD_W + CMD_EN_POS] &&
      thr_q[GRADE_W-1:0] == cmd_last_q[CMD_THR_POS +: GRADE_W])
      else $error("command word fields landed in the wrong slots");
   a_grade_hold_idle: assert property (!grade_valid |=> $stable(grade_q))
      else $error("grades changed without a new symbol");
   a_quality_clears: assert property (s_none_failing ##1 s_none_failing |-> !quality_out)
      else $error("output high with no enabled failure");
   a_all_disabled_quiet: assert property (en_q == EN_RESET |=> !quality_out)
      else $error("output driven with every check disabled");
   a_quality_matches_fails: assert property (quality_out == (|fail_q))
      else $error("output disagrees with the per-slot failure flags");
   a_write_answer: assert property (do_write |=> s_axi_bvalid)
      else $error("write performed without a response");
   a_resp_holds: assert property (s_resp_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before it was taken");
   a_read_holds: assert property (s_read_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before it was taken");
   a_fail_event_sticky: assert property (irq_set[IRQ_FAIL_BIT] |=> irq_stat_q[IRQ_FAIL_BIT])
      else $error("pass to fail event not recorded");
   a_irq_level: assert property (1'b1 |=> irq == (|(irq_stat_q & $past(irq_mask_q))))
      else $error("interrupt level does not follow the masked status");
endmodule

// *** hw/lqog_pkg.sv ***
// constants shared by the linear quality output gate
// assumes a single clock domain and a 32-bit AXI4-Lite register port
package lqog_pkg;
   // parameter slots, in command order
   localparam int NPAR = 10;
   localparam int GRADE_W = 2;
   localparam int PAR_OVERALL = 0;
   localparam int PAR_EDGE = 1;
   localparam int PAR_DECODE = 2;
   localparam int PAR_CONTRAST = 3;
   localparam int PAR_MIN_REFL = 4;
   localparam int PAR_MIN_EDGE = 5;
   localparam int PAR_MODULATION = 6;
   localparam int PAR_DEFECTS = 7;
   localparam int PAR_DECODABILITY = 8;
   localparam int PAR_QUIET_ZONE = 9;

   // grade codes, higher is better
   localparam logic [GRADE_W-1:0] GRADE_D = 2'h0;
   localparam logic [GRADE_W-1:0] GRADE_C = 2'h1;
   localparam logic [GRADE_W-1:0] GRADE_B = 2'h2;
   localparam logic [GRADE_W-1:0] GRADE_A = 2'h3;
   localparam logic EN_OFF = 1'h0;
   localparam logic EN_ON = 1'h1;

   localparam logic [NPAR-1:0] EN_RESET = {NPAR{EN_OFF}};
   localparam logic [NPAR*GRADE_W-1:0] THR_RESET = {NPAR{GRADE_B}};
   localparam logic [NPAR*GRADE_W-1:0] GRADE_RESET = {NPAR{GRADE_A}};

   // packed command word: per slot enable then threshold
   localparam int CMD_FIELD_W = 3;
   localparam int CMD_EN_POS = 0;
   localparam int CMD_THR_POS = 1;

   // register byte offsets
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_THRESH = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_GRADE = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_FAILS = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h18;

   localparam int IRQ_W = 2;
   localparam int IRQ_FAIL_BIT = 0;
   localparam int IRQ_GRADE_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/lqog_cmp.sv ***
// per-slot below-threshold comparison
// assumes grades and thresholds share the same packed layout
`timescale 1ns/1ns
module lqog_cmp
   import lqog_pkg::*;
(
   input wire logic [NPAR-1:0] en,
   input wire logic [NPAR*GRADE_W-1:0] thr,
   input wire logic [NPAR*GRADE_W-1:0] grade,
   output logic [NPAR-1:0] fail
);
   always_comb begin
      for (int i = 0; i < NPAR; i++) begin
         // unsigned compare works because codes rise with quality
         fail[i] = en[i] && (grade[i*GRADE_W +: GRADE_W] < thr[i*GRADE_W +: GRADE_W]);
      end
   end
endmodule

// *** tb/lqog_grader.sv ***
// grade source model: hands one packed grade set to the gate per request
// assumes requests come from the bench right after a rising edge
`timescale 1ns/1ns
module lqog_grader
   import lqog_pkg::*;
(
   input wire logic aclk,
   input wire logic send,
   input wire logic [NPAR*GRADE_W-1:0] val,
   output logic grade_valid,
   output logic [NPAR*GRADE_W-1:0] grade_in
);
   initial grade_in = '0;
   always @(posedge aclk) begin
      grade_valid <= send;
      // two-bit four-level codes per slot, 0 worst to 3 best
      // off-strobe the bus toggles so stale grades never look valid
      grade_in <= send ? val : ~grade_in;
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the linear quality output gate
// assumes lqog_top behind AXI4-Lite and the lqog_grader source model
`timescale 1ns/1ns
module tb_top
   import lqog_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, gsend = 0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [NPAR*GRADE_W-1:0] gval = '0, gin;
   logic awready, wready, bvalid, arready, rvalid, gvld, q, irq;
   logic [1:0] bresp, rresp;
   int fails = 0, n_checks = 0, cyc = 0;
   logic [31:0] exp_d[$];
   logic [1:0] exp_r[$], exp_b[$];

   always #20 aclk = ~aclk;

   lqog_top i_dut(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .grade_in(gin), .grade_valid(gvld), .quality_out(q), .irq(irq));
   lqog_grader i_grd(.aclk(aclk), .send(gsend), .val(gval), .grade_valid(gvld), .grade_in(gin));

   task summarize;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task cq(input logic e);
      chk({31'h0, q}, {31'h0, e}, "quality");
   endtask

   task ci(input logic e);
      chk({31'h0, irq}, {31'h0, e}, "irq");
   endtask

   // responses are judged here, in handshake order, against the notes queued by the tasks
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         chk(rdata, exp_d.pop_front(), "rdata");
         chk({30'h0, rresp}, {30'h0, exp_r.pop_front()}, "rresp");
      end
      if (bvalid && bready)
         chk({30'h0, bresp}, {30'h0, exp_b.pop_front()}, "bresp");
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end

   task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!(bvalid && bready));
      bready <= 0;
   endtask

   task rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      exp_d.push_back(d);
      exp_r.push_back(r);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!(rvalid && rready));
      rready <= 0;
      #1;
   endtask

   // grader adds one cycle, latch one, compare one
   task gs(input logic [19:0] v);
      @(posedge aclk);
      gval <= v;
      gsend <= 1;
      @(posedge aclk);
      gsend <= 0;
      repeat (3) @(posedge aclk);
      #1;
   endtask

   function automatic logic qx(input logic [9:0] en, input logic [19:0] t, input logic [19:0] g);
      qx = 0;
      for (int i = 0; i < NPAR; i++)
         if (en[i] && g[2*i+:2] < t[2*i+:2]) qx = 1;
   endfunction

   initial begin
      logic [19:0] g, t;
      logic [9:0] e;
      logic [31:0] c;
      void'($urandom(32'h76a2fa0b));
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < NPAR; i++) begin
         t[2*i+:2] = 2'h2;
         c[3*i+:3] = 3'h4;
      end
      c[31:30] = 2'h0;
      rd(ADDR_ENABLE, 32'h0, RESP_OKAY);
      rd(ADDR_THRESH, {12'h0, t}, RESP_OKAY);
      rd(ADDR_CMD, c, RESP_OKAY);
      rd(8'h1C, 32'h0, RESP_SLVERR);
      wr(8'h1C, $urandom, RESP_SLVERR);
      wr(ADDR_GRADE, 32'h0, RESP_OKAY);
      rd(ADDR_GRADE, 32'hFFFFF, RESP_OKAY);
      $display("test reset done");
      for (int i = 0; i < NPAR; i++) begin
         wr(ADDR_ENABLE, 32'h1 << i, RESP_OKAY);
         g = '1;
         g[2*i+:2] = 2'h1;
         gs(g);
         cq(1);
         rd(ADDR_FAILS, 32'h1 << i, RESP_OKAY);
         g[2*i+:2] = 2'h2;
         g[2*((i+1)%NPAR)+:2] = 2'h0;
         gs(g);
         cq(0);
      end
      $display("test slots done");
      wr(ADDR_ENABLE, 32'h1, RESP_OKAY);
      for (int tc = 0; tc < 4; tc++) begin
         wr(ADDR_THRESH, 32'(tc), RESP_OKAY);
         for (int gc = 0; gc < 4; gc++) begin
            g = 20'($urandom);
            g[1:0] = 2'(gc);
            gs(g);
            cq(gc < tc);
         end
      end
      $display("test codes done");
      repeat (4) begin
         c = $urandom;
         c[31:30] = 2'h0;
         for (int i = 0; i < NPAR; i++) begin
            e[i] = c[3*i];
            t[2*i+:2] = c[3*i+1+:2];
         end
         wr(ADDR_CMD, c, RESP_OKAY);
         rd(ADDR_ENABLE, {22'h0, e}, RESP_OKAY);
         rd(ADDR_THRESH, {12'h0, t}, RESP_OKAY);
         rd(ADDR_CMD, c, RESP_OKAY);
         g = 20'($urandom);
         gs(g);
         cq(qx(e, t, g));
      end
      $display("test command done");
      wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
      wr(ADDR_ENABLE, 32'h1, RESP_OKAY);
      wr(ADDR_THRESH, 32'h3, RESP_OKAY);
      gs('1);
      cq(0);
      // earlier traffic left both events pending
      rd(ADDR_IRQ_STAT, 32'h3, RESP_OKAY);
      g = '1;
      g[1:0] = 2'h2;
      gs(g);
      cq(1);
      ci(0);
      wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      #1;
      ci(1);
      rd(ADDR_IRQ_STAT, 32'h3, RESP_OKAY);
      ci(0);
      wr(ADDR_IRQ_MASK, 32'h2, RESP_OKAY);
      rd(ADDR_IRQ_MASK, 32'h2, RESP_OKAY);
      gs(g);
      ci(1);
      rd(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
      ci(0);
      $display("test interrupt done");
      summarize();
   end
endmodule
